//--- vfclip_top.sv
// video frame clipper: stream in, clipped stream out, APB register slave
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "vfclip_consts.svh"
module vfclip_top #(
  parameter bit RUNTIME_CTRL = 1'b0                     // control port writable
) (
  input wire logic clock,                               // 40 MHz clock
  input wire logic rstn,                                // sync reset, low
  input wire logic ce,                                  // clock enable
  input wire logic psel,                                // apb select
  input wire logic penable,                             // apb enable
  input wire logic pwrite,                              // apb direction
  input wire logic [7:0] paddr,                         // apb byte address
  input wire logic [31:0] pwdata,                       // apb write data
  output logic [31:0] prdata,                           // apb read data
  output logic pready,                                  // apb ready
  output logic pslverr,                                 // apb error
  input wire logic in_valid,                            // input beat valid
  output logic in_ready,                                // input beat taken
  input wire logic [`VFC_PAR*`VFC_BPS-1:0] in_data,     // input samples
  input wire logic in_sop,                              // first beat of field
  input wire logic in_eop,                              // last beat of field
  output logic out_valid,                               // output beat valid
  input wire logic out_ready,                           // sink accepts
  output logic [`VFC_PAR*`VFC_BPS-1:0] out_data,        // output samples
  output logic out_sop,                                 // first kept beat
  output logic out_eop                                  // last kept beat
);
  localparam int DW = `VFC_PAR * `VFC_BPS;

  // ************************************************************
  // registers
  // ************************************************************
  logic mode_reg;
  logic mode_next;
  logic [15:0] left_reg;
  logic [15:0] left_next;
  logic [15:0] right_reg;
  logic [15:0] right_next;
  logic [15:0] top_reg;
  logic [15:0] top_next;
  logic [15:0] bottom_reg;
  logic [15:0] bottom_next;
  logic [15:0] width_reg;
  logic [15:0] width_next;
  logic [15:0] height_reg;
  logic [15:0] height_next;
  logic [15:0] in_w_reg;
  logic [15:0] in_w_next;
  logic [15:0] in_h_reg;
  logic [15:0] in_h_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [15:0] wv;

  // ************************************************************
  // stream state
  // ************************************************************
  vfclip_pkg::vfclip_state_t st_reg;
  vfclip_pkg::vfclip_state_t st_next;
  logic first_reg;
  logic first_next;
  logic [16:0] x0_reg;
  logic [16:0] x0_next;
  logic [16:0] x1_reg;
  logic [16:0] x1_next;
  logic [16:0] y0_reg;
  logic [16:0] y0_next;
  logic [16:0] y1_reg;
  logic [16:0] y1_next;
  logic ov_reg;
  logic ov_next;
  logic [DW-1:0] od_reg;
  logic [DW-1:0] od_next;
  logic osop_reg;
  logic osop_next;
  logic oeop_reg;
  logic oeop_next;
  logic [16:0] lx0;
  logic [16:0] lx1;
  logic [16:0] ly0;
  logic [16:0] ly1;
  logic [16:0] bx0;
  logic [16:0] bx1;
  logic [16:0] by0;
  logic [16:0] by1;
  logic accept;
  logic active;
  logic keep;
  logic last;

  vfclip_pos_if pif ();

  vfclip_pos u_vfclip_pos (
    .clock (clock),
    .rstn (rstn),
    .ce (ce),
    .p (pif)
  );

  // ************************************************************
  // apb slave
  // ************************************************************
  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & RUNTIME_CTRL;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wv = pwdata[15:0];
  assign prdata = rdata_reg;

  always_comb begin
    unique case (paddr)
      `VFC_A_CTRL, `VFC_A_LEFT, `VFC_A_RIGHT, `VFC_A_TOP,
      `VFC_A_BOTTOM, `VFC_A_WIDTH, `VFC_A_HEIGHT, `VFC_A_IN_W,
      `VFC_A_IN_H, `VFC_A_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    mode_next = mode_reg;
    left_next = left_reg;
    right_next = right_reg;
    top_next = top_reg;
    bottom_next = bottom_reg;
    width_next = width_reg;
    height_next = height_reg;
    in_w_next = in_w_reg;
    in_h_next = in_h_reg;
    if (wr_en) begin
      unique case (paddr)
        `VFC_A_CTRL: mode_next = pwdata[`VFC_CTRL_MODE];
        `VFC_A_LEFT: left_next = wv;
        `VFC_A_RIGHT: right_next = wv;
        `VFC_A_TOP: top_next = wv;
        `VFC_A_BOTTOM: bottom_next = wv;
        `VFC_A_WIDTH: width_next = wv;
        `VFC_A_HEIGHT: height_next = wv;
        `VFC_A_IN_W: in_w_next = wv;
        `VFC_A_IN_H: in_h_next = wv;
        default: ;
      endcase
    end
    rdata_next = rdata_reg;
    if (rd_setup) begin
      unique case (paddr)
        `VFC_A_CTRL: rdata_next = {31'h0, mode_reg};
        `VFC_A_LEFT: rdata_next = {16'h0000, left_reg};
        `VFC_A_RIGHT: rdata_next = {16'h0000, right_reg};
        `VFC_A_TOP: rdata_next = {16'h0000, top_reg};
        `VFC_A_BOTTOM: rdata_next = {16'h0000, bottom_reg};
        `VFC_A_WIDTH: rdata_next = {16'h0000, width_reg};
        `VFC_A_HEIGHT: rdata_next = {16'h0000, height_reg};
        `VFC_A_IN_W: rdata_next = {16'h0000, in_w_reg};
        `VFC_A_IN_H: rdata_next = {16'h0000, in_h_reg};
        `VFC_A_STATUS: begin
          rdata_next = 32'h0;
          rdata_next[`VFC_STAT_BUSY] = (st_reg == vfclip_pkg::ST_FIELD);
          rdata_next[`VFC_STAT_LINE +: 16] = pif.y;
        end
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_reg <= `VFC_RST_MODE;
      left_reg <= `VFC_RST_LEFT;
      right_reg <= `VFC_RST_RIGHT;
      top_reg <= `VFC_RST_TOP;
      bottom_reg <= `VFC_RST_BOTTOM;
      width_reg <= `VFC_RST_WIDTH;
      height_reg <= `VFC_RST_HEIGHT;
      in_w_reg <= `VFC_RST_IN_W;
      in_h_reg <= `VFC_RST_IN_H;
      rdata_reg <= 32'h0;
    end else if (ce) begin
      mode_reg <= mode_next;
      left_reg <= left_next;
      right_reg <= right_next;
      top_reg <= top_next;
      bottom_reg <= bottom_next;
      width_reg <= width_next;
      height_reg <= height_next;
      in_w_reg <= in_w_next;
      in_h_reg <= in_h_next;
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // region bounds
  // ************************************************************
  // offsets past the frame size wrap; software must avoid them
  always_comb begin
    lx0 = {1'b0, left_reg};
    ly0 = {1'b0, top_reg};
    if (mode_reg == vfclip_pkg::MODE_RECT) begin
      lx1 = lx0 + {1'b0, width_reg};
      ly1 = ly0 + {1'b0, height_reg};
    end else begin
      lx1 = {1'b0, in_w_reg} - {1'b0, right_reg};
      ly1 = {1'b0, in_h_reg} - {1'b0, bottom_reg};
    end
    if (lx1 > lx0 + `VFC_MAX_W) begin
      lx1 = lx0 + `VFC_MAX_W;
    end
    if (ly1 > ly0 + `VFC_MAX_H) begin
      ly1 = ly0 + `VFC_MAX_H;
    end
  end

  // bounds are frozen at start of field so a field never tears
  assign bx0 = in_sop ? lx0 : x0_reg;
  assign bx1 = in_sop ? lx1 : x1_reg;
  assign by0 = in_sop ? ly0 : y0_reg;
  assign by1 = in_sop ? ly1 : y1_reg;

  // ************************************************************
  // stream path
  // ************************************************************
  assign in_ready = ~ov_reg | out_ready;
  assign accept = in_valid & in_ready & ce;
  assign active = accept & (in_sop | (st_reg == vfclip_pkg::ST_FIELD));
  assign pif.adv = active;
  assign pif.sop = in_sop;
  assign pif.width = in_w_reg;

  assign keep = ({1'b0, pif.x} >= bx0) && ({1'b0, pif.x} < bx1)
             && ({1'b0, pif.y} >= by0) && ({1'b0, pif.y} < by1);
  assign last = ({1'b0, pif.x} == bx1 - 17'h00001)
             && ({1'b0, pif.y} == by1 - 17'h00001)
             && (pif.plane == 2'(`VFC_SEQ - 1));

  always_comb begin
    st_next = st_reg;
    first_next = first_reg;
    x0_next = x0_reg;
    x1_next = x1_reg;
    y0_next = y0_reg;
    y1_next = y1_reg;
    ov_next = ov_reg;
    od_next = od_reg;
    osop_next = osop_reg;
    oeop_next = oeop_reg;
    if (active) begin
      if (in_sop) begin
        x0_next = lx0;
        x1_next = lx1;
        y0_next = ly0;
        y1_next = ly1;
      end
      st_next = in_eop ? vfclip_pkg::ST_IDLE : vfclip_pkg::ST_FIELD;
      first_next = (in_sop | first_reg) & ~keep;
    end
    // frame flags follow valid, so a flag never stands without a beat
    if (accept) begin
      ov_next = active & keep;
      od_next = in_data;
      osop_next = active & keep & (in_sop | first_reg);
      oeop_next = active & keep & last;
    end else if (out_ready) begin
      ov_next = 1'b0;
      osop_next = 1'b0;
      oeop_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_reg <= vfclip_pkg::ST_IDLE;
      first_reg <= 1'b0;
      x0_reg <= 17'h0;
      x1_reg <= 17'h0;
      y0_reg <= 17'h0;
      y1_reg <= 17'h0;
      ov_reg <= 1'b0;
      od_reg <= '0;
      osop_reg <= 1'b0;
      oeop_reg <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
      first_reg <= first_next;
      x0_reg <= x0_next;
      x1_reg <= x1_next;
      y0_reg <= y0_next;
      y1_reg <= y1_next;
      ov_reg <= ov_next;
      od_reg <= od_next;
      osop_reg <= osop_next;
      oeop_reg <= oeop_next;
    end
  end

  assign out_valid = ov_reg;
  assign out_data = od_reg;
  assign out_sop = osop_reg;
  assign out_eop = oeop_reg;
endmodule : vfclip_top

//--- vfclip_consts.svh
// constants of the video frame clipper: offsets, reset values, build sizes
`ifndef VFCLIP_CONSTS_SVH
`define VFCLIP_CONSTS_SVH

// build-time sizes
`define VFC_MAX_W 17'h00400
`define VFC_MAX_H 17'h00300
`define VFC_BPS 8
`define VFC_SEQ 3
`define VFC_PAR 1
`define VFC_CW 16

// register byte offsets
`define VFC_A_CTRL 8'h00
`define VFC_A_LEFT 8'h04
`define VFC_A_RIGHT 8'h08
`define VFC_A_TOP 8'h0C
`define VFC_A_BOTTOM 8'h10
`define VFC_A_WIDTH 8'h14
`define VFC_A_HEIGHT 8'h18
`define VFC_A_IN_W 8'h1C
`define VFC_A_IN_H 8'h20
`define VFC_A_STATUS 8'h24

// field positions
`define VFC_CTRL_MODE 0
`define VFC_STAT_BUSY 0
`define VFC_STAT_LINE 16

// reset values
`define VFC_RST_MODE 1'b0
`define VFC_RST_LEFT 16'h000A
`define VFC_RST_RIGHT 16'h000A
`define VFC_RST_TOP 16'h000A
`define VFC_RST_BOTTOM 16'h000A
`define VFC_RST_WIDTH 16'h000A
`define VFC_RST_HEIGHT 16'h000A
`define VFC_RST_IN_W 16'h0400
`define VFC_RST_IN_H 16'h0300

`endif

//--- vfclip_pkg.sv
// types of the video frame clipper
package vfclip_pkg;
  typedef enum logic {MODE_OFFSETS, MODE_RECT} vfclip_mode_t;
  typedef enum logic [0:0] {ST_IDLE, ST_FIELD} vfclip_state_t;
endpackage : vfclip_pkg

//--- vfclip_pos_if.sv
// position of the incoming beat within the field
`timescale 1ns/1ps
interface vfclip_pos_if;
  logic adv;
  logic sop;
  logic [15:0] width;
  logic [1:0] plane;
  logic [15:0] x;
  logic [15:0] y;
  modport pos (input adv, input sop, input width, output plane, output x, output y);
  modport ctl (output adv, output sop, output width, input plane, input x, input y);
endinterface : vfclip_pos_if

//--- vfclip_pos.sv
// plane, column and line counter of the input stream
`timescale 1ns/1ps
`include "vfclip_consts.svh"
module vfclip_pos (
  input wire logic clock,      // 40 MHz clock
  input wire logic rstn,       // sync reset, low
  input wire logic ce,         // clock enable
  vfclip_pos_if.pos p          // position port
);
  logic [1:0] p_reg;
  logic [1:0] p_next;
  logic [15:0] x_reg;
  logic [15:0] x_next;
  logic [15:0] y_reg;
  logic [15:0] y_next;

  // start of field forces the current beat to the origin
  assign p.plane = p.sop ? 2'h0 : p_reg;
  assign p.x = p.sop ? 16'h0000 : x_reg;
  assign p.y = p.sop ? 16'h0000 : y_reg;

  always_comb begin
    p_next = p_reg;
    x_next = x_reg;
    y_next = y_reg;
    if (p.adv) begin
      p_next = p.plane + 2'h1;
      x_next = p.x;
      y_next = p.y;
      if (p_next == 2'(`VFC_SEQ)) begin
        p_next = 2'h0;
        x_next = p.x + 16'h0001;
        if (x_next >= p.width) begin
          x_next = 16'h0000;
          y_next = p.y + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      p_reg <= 2'h0;
      x_reg <= 16'h0000;
      y_reg <= 16'h0000;
    end else if (ce) begin
      p_reg <= p_next;
      x_reg <= x_next;
      y_reg <= y_next;
    end
  end
endmodule : vfclip_pos

//--- vfclip_properties.sv
// concurrent assertions on the ports of the video frame clipper
`timescale 1ns/1ps
`include "vfclip_consts.svh"
module vfc_props (
  input wire logic clock, // clock
  input wire logic rstn, // sync reset, low
  input wire logic ce, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic in_valid, // input valid
  input wire logic in_ready, // input taken
  input wire logic out_valid, // output valid
  input wire logic out_ready, // sink accepts
  input wire logic [`VFC_PAR*`VFC_BPS-1:0] out_data, // output samples
  input wire logic out_sop, // first kept beat
  input wire logic out_eop // last kept beat
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence s_wr_left;
    psel && penable && pwrite && ce && paddr == `VFC_A_LEFT;
  endsequence
  sequence s_rd_left;
    psel && !penable && !pwrite && ce && paddr == `VFC_A_LEFT ##1 psel && penable && ce;
  endsequence
  AST_WR_RB: assert property (s_wr_left ##1 s_rd_left |->
    prdata[15:0] == $past(pwdata[15:0], 2)) else $error("left offset readback differs");
  AST_RD_HI: assert property (psel && penable && !pwrite && paddr < `VFC_A_STATUS
    |-> prdata[31:16] == 16'h0000) else $error("unused read bits set");
  AST_READY: assert property (pready) else $error("apb wait state seen");
  AST_ERR: assert property (psel && penable && !pwrite && paddr > `VFC_A_STATUS
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped read not refused");
  AST_NOERR: assert property (psel && penable && paddr <= `VFC_A_STATUS
    && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped access refused");
  AST_FREE: assert property (!out_valid |-> in_ready) else $error("idle but input held");
  AST_STALL: assert property (out_valid && !out_ready |-> !in_ready)
    else $error("input taken while output stalled");
  AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_sop) && $stable(out_eop)) else $error("output changed while stalled");
  AST_CAUSE: assert property ($rose(out_valid) |-> $past(in_valid && in_ready && ce))
    else $error("output beat without input beat");
  AST_FLAGS: assert property (out_sop || out_eop |-> out_valid)
    else $error("frame flag without valid");
endmodule : vfc_props

bind vfclip_top vfc_props u_vfc_props (.clock(clock), .rstn(rstn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sop(out_sop),
  .out_eop(out_eop));

//--- vfc_sink.sv
// downstream sink model with optional random back-pressure
`timescale 1ns/1ps
module vfc_sink (
  input wire logic clock, // clock
  input wire logic rstn, // sync reset, low
  input wire logic stall_en, // allow back-pressure
  output logic out_ready // sink accepts
);
  int seed_sink = 32'h2a5e;
  logic [31:0] rnd;
  // roughly one cycle in four refused, so the clipper must hold its output
  always @(posedge clock) begin
    rnd = $random(seed_sink);
    out_ready <= !rstn || !stall_en || rnd[0] || rnd[1];
  end
endmodule : vfc_sink

//--- testbench.sv
// self-checking bench of the video frame clipper
`timescale 1ns/1ps
`include "vfclip_consts.svh"
module testbench;
  logic clock, rstn, ce, psel, penable, pwrite, pready, pslverr, slv, stall_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic in_valid, in_ready, in_sop, in_eop, out_valid, out_ready, out_sop, out_eop;
  logic [`VFC_PAR*`VFC_BPS-1:0] in_data, out_data;
  logic [9:0] expq[$];
  logic [9:0] got;
  int err_total, n_checks, seed, iw, ih;
  // mode, left, right, top, bottom, width, height
  int cfg[3][7] = '{'{0, 2, 1, 1, 2, 0, 0}, '{1, 1, 0, 2, 0, 3, 2}, '{0, 0, 0, 0, 0, 0, 0}};
  logic [7:0] ra[9] = '{`VFC_A_CTRL, `VFC_A_LEFT, `VFC_A_RIGHT, `VFC_A_TOP, `VFC_A_BOTTOM,
    `VFC_A_WIDTH, `VFC_A_HEIGHT, `VFC_A_IN_W, `VFC_A_IN_H};
  logic [15:0] rv[9] = '{{15'h0000, `VFC_RST_MODE}, `VFC_RST_LEFT, `VFC_RST_RIGHT,
    `VFC_RST_TOP, `VFC_RST_BOTTOM, `VFC_RST_WIDTH, `VFC_RST_HEIGHT, `VFC_RST_IN_W, `VFC_RST_IN_H};

  vfclip_top #(.RUNTIME_CTRL(1'b1)) u_vfclip_top (.clock(clock), .rstn(rstn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sop(out_sop),
    .out_eop(out_eop));
  vfc_sink u_vfc_sink (.clock(clock), .rstn(rstn), .stall_en(stall_en), .out_ready(out_ready));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ************************
  // shared tasks
  // ************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // leaves psel up so a following setup cycle can come at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    slv = pslverr;
  endtask : apb

  task automatic apb_idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb_idle

  task automatic beat(input logic [7:0] d, input logic s, input logic e);
    in_valid <= 1'b1;
    in_data <= d;
    in_sop <= s;
    in_eop <= e;
    @(posedge clock);
    while (in_ready !== 1'b1) @(posedge clock);
  endtask : beat

  task automatic field(input int c);
    int l, t, lx, ly;
    logic [7:0] d;
    l = cfg[c][1];
    t = cfg[c][3];
    lx = cfg[c][0] ? l + cfg[c][5] - 1 : iw - cfg[c][2] - 1;
    ly = cfg[c][0] ? t + cfg[c][6] - 1 : ih - cfg[c][4] - 1;
    beat(8'h5A, 1'b0, 1'b0);
    for (int y = 0; y < ih; y++) begin
      for (int x = 0; x < iw; x++) begin
        for (int p = 0; p < `VFC_SEQ; p++) begin
          d = 8'($random(seed));
          beat(d, x == 0 && y == 0 && p == 0, x == iw - 1 && y == ih - 1 && p == 2);
          if (x >= l && y >= t && x <= lx && y <= ly) begin
            expq.push_back({x == l && y == t && p == 0, x == lx && y == ly && p == 2, d});
          end
        end
      end
    end
    in_valid <= 1'b0;
    @(posedge clock);
  endtask : field

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // ************************
  // output monitor
  // ************************
  always @(posedge clock) begin
    if (rstn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (expq.size() == 0) begin
        check(32'({out_sop, out_eop, out_data}), 32'hFFFF_FFFF);
      end else begin
        got = expq.pop_front();
        check(32'({out_sop, out_eop, out_data}), 32'(got));
      end
    end
  end

  initial begin
    #500000;
    err_total++;
    print_verdict;
  end

  initial begin
    seed = 32'h2a5e;
    {rstn, psel, penable, pwrite, in_valid, in_sop, in_eop, stall_en} = 8'h00;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    in_data = 8'h00;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      check(rd, {16'h0000, rv[i]});
    end
    // idle status: outside a field, line counter at zero
    apb(1'b0, `VFC_A_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(slv), 32'h0000_0000);
    apb(1'b0, 8'h28, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(slv), 32'h0000_0001);
    iw = 8;
    ih = 6;
    // offsets stay within the image size
    apb(1'b1, `VFC_A_IN_W, iw);
    apb(1'b1, `VFC_A_IN_H, ih);
    for (int c = 0; c < 3; c++) begin
      stall_en <= (c != 1);
      apb(1'b1, `VFC_A_CTRL, cfg[c][0]);
      for (int i = 1; i < 7; i++) begin
        apb(1'b1, ra[i], cfg[c][i]);
        apb(1'b0, ra[i], 32'h0000_0000);
        check(rd, cfg[c][i]);
      end
      apb_idle;
      field(c);
      for (int n = 0; n < 600 && expq.size() > 0; n++) @(posedge clock);
      check(expq.size(), 32'h0000_0000);
    end
    print_verdict;
  end
endmodule : testbench
